// File: design/meter_link_pkg.sv
// ****************************************
// shared constants and types
// ****************************************
package meter_link_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int ASTER_WAIT_MS = 50;
  localparam int DOLLAR_WAIT_MS = 2;
  localparam int ASTER_WAIT_CYC = CLK_HZ / 1000 * ASTER_WAIT_MS;
  localparam int DOLLAR_WAIT_CYC = CLK_HZ / 1000 * DOLLAR_WAIT_MS;
  localparam int WAIT_W = 20;
  localparam int FRAME_W = 12;
  // register offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_RXDATA = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // field positions
  localparam int CFG_DIV_LSB = 0;
  localparam int CFG_DATA8_BIT = 16;
  localparam int CFG_PAR_LSB = 17;
  localparam int CTRL_NOREPLY_BIT = 0;
  localparam int RXDATA_VALID_BIT = 8;
  localparam int TXDATA_LAST_BIT = 8;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_DOLLAR_BIT = 2;
  localparam int STAT_HOLD_BIT = 3;
  localparam int STAT_RXV_BIT = 4;
  localparam int STAT_WDONE_BIT = 5;
  // reset values
  localparam logic [15:0] CFG_DIV_RST = 16'h0823;
  localparam logic CFG_DATA8_RST = 1'h1;
  // characters
  localparam logic [7:0] TERM_ASTER = 8'h2a;
  localparam logic [7:0] TERM_DOLLAR = 8'h24;
  typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_ODD = 2'b01, PAR_EVEN = 2'b10} parity_t;
  typedef enum logic [1:0] {ST_RECV = 2'b00, ST_EXEC = 2'b01, ST_SEND = 2'b10} link_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10,
    RX_STOP = 2'b11} rx_state_t;
endpackage : meter_link_pkg

// File: design/rx_link_if.sv
`timescale 1ns/1ns
// ****************************************
// receiver carrier
// ****************************************
interface rx_link_if;
  logic en;
  logic [15:0] div;
  logic data8;
  logic par_en;
  logic vld;
  logic [7:0] chr;
  modport rx (input en, input div, input data8, input par_en, output vld, output chr);
  modport ctl (output en, output div, output data8, output par_en, input vld, input chr);
endinterface : rx_link_if

// File: design/serial_char_rx.sv
`timescale 1ns/1ns
// ****************************************
// character receiver
// ****************************************
module serial_char_rx (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // line
  input wire logic rx_pin,
  // control side
  rx_link_if.rx lnk
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic armed;
    meter_link_pkg::rx_state_t st;
    logic [15:0] cnt;
    logic [3:0] nbit;
    logic [7:0] sh;
    logic vld;
    logic [7:0] chr;
  } rx_regs_t;

  rx_regs_t q_r;
  rx_regs_t q_nxt;
  logic [3:0] total;

  always_comb begin
    q_nxt = q_r;
    total = (lnk.data8 ? 4'h8 : 4'h7) + {3'h0, lnk.par_en};
    q_nxt.s1 = rx_pin;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    if (q_r.s2 == q_r.s3) begin
      q_nxt.lvl = q_r.s3;
    end
    q_nxt.vld = 1'b0;
    if (q_r.lvl) begin
      q_nxt.armed = 1'b1;
    end
    q_nxt.cnt = q_r.cnt - 16'h0001;
    unique case (q_r.st)
      meter_link_pkg::RX_IDLE: begin
        if (!q_r.lvl && q_r.armed) begin
          q_nxt.st = meter_link_pkg::RX_START;
          q_nxt.cnt = {1'b0, lnk.div[15:1]};
        end
      end
      meter_link_pkg::RX_START: begin
        if (q_r.cnt == 16'h0000) begin
          q_nxt.cnt = lnk.div - 16'h0001;
          q_nxt.nbit = 4'h0;
          q_nxt.st = q_r.lvl ? meter_link_pkg::RX_IDLE : meter_link_pkg::RX_BITS;
        end
      end
      meter_link_pkg::RX_BITS: begin
        if (q_r.cnt == 16'h0000) begin
          q_nxt.cnt = lnk.div - 16'h0001;
          if (q_r.nbit < (lnk.data8 ? 4'h8 : 4'h7)) begin
            q_nxt.sh = {q_r.lvl, q_r.sh[7:1]};
          end
          q_nxt.nbit = q_r.nbit + 4'h1;
          if (q_r.nbit == total - 4'h1) begin
            q_nxt.st = meter_link_pkg::RX_STOP;
          end
        end
      end
      meter_link_pkg::RX_STOP: begin
        if (q_r.cnt == 16'h0000) begin
          q_nxt.chr = lnk.data8 ? q_r.sh : {1'b0, q_r.sh[7:1]};
          q_nxt.vld = 1'b1;
          q_nxt.armed = q_r.lvl;
          q_nxt.st = meter_link_pkg::RX_IDLE;
        end
      end
    endcase
    if (!lnk.en) begin
      q_nxt.st = meter_link_pkg::RX_IDLE;
      q_nxt.vld = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1, armed: 1'b0,
        st: meter_link_pkg::RX_IDLE, cnt: 16'h0000, nbit: 4'h0, sh: 8'h00,
        vld: 1'b0, chr: 8'h00};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign lnk.vld = q_r.vld;
  assign lnk.chr = q_r.chr;
endmodule : serial_char_rx

// File: design/meter_serial_link.sv
`timescale 1ns/1ns
module meter_serial_link #(
  parameter int ASTER_WAIT_CYC = meter_link_pkg::ASTER_WAIT_CYC,
  parameter int DOLLAR_WAIT_CYC = meter_link_pkg::DOLLAR_WAIT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // serial line
  input wire logic rxd,
  output logic txd,
  output logic txd_oe
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    meter_link_pkg::link_state_t st;
    logic [15:0] div;
    logic data8;
    meter_link_pkg::parity_t par;
    logic [7:0] rx_chr;
    logic rx_v;
    logic dollar;
    logic [meter_link_pkg::WAIT_W-1:0] wcnt;
    logic [7:0] hold;
    logic hold_last;
    logic hold_v;
    logic [meter_link_pkg::FRAME_W-1:0] frm;
    logic [3:0] left;
    logic [15:0] bcnt;
    logic tx_busy;
    logic cur_last;
    logic txd;
    logic oe;
    logic [31:0] rdata;
  } link_regs_t;

  link_regs_t q_r;
  link_regs_t q_nxt;

  logic [meter_link_pkg::WAIT_W-1:0] wait_target;
  logic wdone;
  logic par_on;
  logic [meter_link_pkg::FRAME_W-1:0] new_frm;
  logic [3:0] new_len;
  logic is_term;

  rx_link_if rxl ();

  // ****************************************
  // receiver
  // ****************************************
  serial_char_rx u_rx (
    .sys_clk(sys_clk),
    .rst(rst),
    .rx_pin(rxd),
    .lnk(rxl.rx)
  );

  assign rxl.en = (q_r.st == meter_link_pkg::ST_RECV);
  assign rxl.div = q_r.div;
  assign rxl.data8 = q_r.data8;
  assign rxl.par_en = par_on;

  // ****************************************
  // frame builder
  // ****************************************
  function automatic logic [meter_link_pkg::FRAME_W-1:0] build_frame(
    input logic [7:0] d,
    input logic d8,
    input meter_link_pkg::parity_t p
  );
    logic [meter_link_pkg::FRAME_W-1:0] f;
    logic [7:0] m;
    logic pb;
    f = '1;
    m = d8 ? d : {1'b0, d[6:0]};
    pb = (p == meter_link_pkg::PAR_ODD) ? ~(^m) : (^m);
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < (d8 ? 8 : 7)) begin
        f[1 + i] = m[i];
      end
    end
    if (p == meter_link_pkg::PAR_ODD || p == meter_link_pkg::PAR_EVEN) begin
      f[d8 ? 9 : 8] = pb;
    end
    return f;
  endfunction : build_frame

  always_comb begin
    par_on = (q_r.par == meter_link_pkg::PAR_ODD) || (q_r.par == meter_link_pkg::PAR_EVEN);
    new_frm = build_frame(q_r.hold, q_r.data8, q_r.par);
    // start + data + parity + stop; 7n gets a second stop
    new_len = 4'h1 + (q_r.data8 ? 4'h8 : 4'h7) + {3'h0, par_on} + 4'h1;
    if (!q_r.data8 && !par_on) begin
      new_len = new_len + 4'h1;
    end
  end

  // ****************************************
  // turn-around delay
  // ****************************************
  always_comb begin
    if (q_r.dollar) begin
      wait_target = DOLLAR_WAIT_CYC[meter_link_pkg::WAIT_W-1:0];
    end else begin
      wait_target = ASTER_WAIT_CYC[meter_link_pkg::WAIT_W-1:0];
    end
    wdone = (q_r.wcnt >= wait_target);
    is_term = (rxl.chr == meter_link_pkg::TERM_ASTER) ||
      (rxl.chr == meter_link_pkg::TERM_DOLLAR);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    q_nxt = q_r;
    q_nxt.rdata = 32'h0000_0000;
    if (!wdone) begin
      q_nxt.wcnt = q_r.wcnt + {{(meter_link_pkg::WAIT_W-1){1'b0}}, 1'b1};
    end

    // register reads
    if (rd_en) begin
      unique case (addr)
        meter_link_pkg::ADDR_CFG: begin
          q_nxt.rdata[meter_link_pkg::CFG_DIV_LSB +: 16] = q_r.div;
          q_nxt.rdata[meter_link_pkg::CFG_DATA8_BIT] = q_r.data8;
          q_nxt.rdata[meter_link_pkg::CFG_PAR_LSB +: 2] = q_r.par;
        end
        meter_link_pkg::ADDR_RXDATA: begin
          q_nxt.rdata[7:0] = q_r.rx_chr;
          q_nxt.rdata[meter_link_pkg::RXDATA_VALID_BIT] = q_r.rx_v;
          q_nxt.rx_v = 1'b0;
        end
        meter_link_pkg::ADDR_STATUS: begin
          q_nxt.rdata[meter_link_pkg::STAT_STATE_LSB +: 2] = q_r.st;
          q_nxt.rdata[meter_link_pkg::STAT_DOLLAR_BIT] = q_r.dollar;
          q_nxt.rdata[meter_link_pkg::STAT_HOLD_BIT] = q_r.hold_v;
          q_nxt.rdata[meter_link_pkg::STAT_RXV_BIT] = q_r.rx_v;
          q_nxt.rdata[meter_link_pkg::STAT_WDONE_BIT] = wdone;
        end
        default: begin
          q_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end

    // register writes
    if (wr_en) begin
      if (addr == meter_link_pkg::ADDR_CFG) begin
        q_nxt.div = wr_data[meter_link_pkg::CFG_DIV_LSB +: 16];
        q_nxt.data8 = wr_data[meter_link_pkg::CFG_DATA8_BIT];
        unique case (wr_data[meter_link_pkg::CFG_PAR_LSB +: 2])
          2'b01: q_nxt.par = meter_link_pkg::PAR_ODD;
          2'b10: q_nxt.par = meter_link_pkg::PAR_EVEN;
          default: q_nxt.par = meter_link_pkg::PAR_NONE;
        endcase
      end
      if (addr == meter_link_pkg::ADDR_CTRL && q_r.st == meter_link_pkg::ST_EXEC &&
          !q_r.hold_v && wr_data[meter_link_pkg::CTRL_NOREPLY_BIT]) begin
        q_nxt.st = meter_link_pkg::ST_RECV;
      end
      if (addr == meter_link_pkg::ADDR_TXDATA && q_r.st != meter_link_pkg::ST_RECV &&
          !q_r.hold_v) begin
        q_nxt.hold = wr_data[7:0];
        q_nxt.hold_last = wr_data[meter_link_pkg::TXDATA_LAST_BIT];
        q_nxt.hold_v = 1'b1;
      end
    end

    // received characters
    if (rxl.vld && q_r.st == meter_link_pkg::ST_RECV) begin
      q_nxt.rx_chr = rxl.chr;
      q_nxt.rx_v = 1'b1;
      if (is_term) begin
        q_nxt.st = meter_link_pkg::ST_EXEC;
        q_nxt.dollar = (rxl.chr == meter_link_pkg::TERM_DOLLAR);
        q_nxt.wcnt = '0;
      end
    end

    // transmitter
    unique case (q_r.st)
      meter_link_pkg::ST_RECV: begin
        q_nxt.txd = 1'b1;
        q_nxt.oe = 1'b0;
      end
      meter_link_pkg::ST_EXEC: begin
        if (q_r.hold_v && wdone) begin
          q_nxt.st = meter_link_pkg::ST_SEND;
          q_nxt.oe = 1'b1;
          q_nxt.frm = new_frm;
          q_nxt.txd = new_frm[0];
          q_nxt.left = new_len;
          q_nxt.bcnt = q_r.div - 16'h0001;
          q_nxt.tx_busy = 1'b1;
          q_nxt.cur_last = q_r.hold_last;
          q_nxt.hold_v = 1'b0;
        end
      end
      meter_link_pkg::ST_SEND: begin
        if (q_r.tx_busy) begin
          q_nxt.bcnt = q_r.bcnt - 16'h0001;
          if (q_r.bcnt == 16'h0000) begin
            q_nxt.bcnt = q_r.div - 16'h0001;
            if (q_r.left == 4'h1) begin
              q_nxt.tx_busy = 1'b0;
              q_nxt.txd = 1'b1;
              if (q_r.cur_last) begin
                q_nxt.st = meter_link_pkg::ST_RECV;
                q_nxt.oe = 1'b0;
              end
            end else begin
              q_nxt.frm = q_r.frm >> 1;
              q_nxt.txd = q_r.frm[1];
              q_nxt.left = q_r.left - 4'h1;
            end
          end
        end else if (q_r.hold_v) begin
          q_nxt.frm = new_frm;
          q_nxt.txd = new_frm[0];
          q_nxt.left = new_len;
          q_nxt.bcnt = q_r.div - 16'h0001;
          q_nxt.tx_busy = 1'b1;
          q_nxt.cur_last = q_r.hold_last;
          q_nxt.hold_v = 1'b0;
        end
      end
      default: begin
        q_nxt.st = meter_link_pkg::ST_RECV;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_r <= '{st: meter_link_pkg::ST_RECV, div: meter_link_pkg::CFG_DIV_RST,
        data8: meter_link_pkg::CFG_DATA8_RST, par: meter_link_pkg::PAR_NONE,
        rx_chr: 8'h00, rx_v: 1'b0, dollar: 1'b0, wcnt: '0, hold: 8'h00,
        hold_last: 1'b0, hold_v: 1'b0, frm: '1, left: 4'h0, bcnt: 16'h0000,
        tx_busy: 1'b0, cur_last: 1'b0, txd: 1'b1, oe: 1'b0, rdata: 32'h0000_0000};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign rd_data = q_r.rdata;
  assign txd = q_r.txd;
  assign txd_oe = q_r.oe;
endmodule : meter_serial_link

// File: verif/meter_link_assertions.sv
`timescale 1ns/1ns
// ****************************************
// link checker
// ****************************************
module meter_link_assertions #(
  parameter int ASTER_WAIT_CYC = 1,
  parameter int DOLLAR_WAIT_CYC = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  // serial line
  input wire logic rxd,
  input wire logic txd,
  input wire logic txd_oe
);
  logic [18:0] cfg_r;
  logic [19:0] low_r;
  logic [19:0] quiet_r;
  logic rxd_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_r <= {2'b00, meter_link_pkg::CFG_DATA8_RST, meter_link_pkg::CFG_DIV_RST};
      low_r <= 20'h0;
      quiet_r <= 20'h0;
    end else begin
      if (wr_en && addr == meter_link_pkg::ADDR_CFG) cfg_r <= wr_data[18:0];
      low_r <= txd ? 20'h0 : low_r + 20'h1;
      if (rxd != rxd_r) quiet_r <= 20'h0;
      else if (quiet_r != 20'hfffff) quiet_r <= quiet_r + 20'h1;
    end
    rxd_r <= rxd;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_idle_mark;
    !txd_oe |-> txd;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("txd low with driver off");
  property p_start_oe;
    $rose(txd_oe) |-> !txd;
  endproperty
  a_start_oe: assert property (p_start_oe) else $error("reply not opened by start");
  property p_bit_len;
    $rose(txd) |-> low_r != 20'h0 && low_r % cfg_r[15:0] == 20'h0;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("low run not whole bits");
  property p_oe_end;
    $fell(txd_oe) |-> txd && $past(txd);
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("driver off before stop");
  property p_oe_hold;
    $rose(txd_oe) |-> txd_oe[*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("driver dropped early");
  property p_turn_wait;
    $rose(txd_oe) |-> quiet_r >= DOLLAR_WAIT_CYC;
  endproperty
  a_turn_wait: assert property (p_turn_wait) else $error("reply too soon");
  property p_rd_zero;
    !rd_en |=> rd_data == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data without read");
  property p_cfg_read;
    rd_en && addr == meter_link_pkg::ADDR_CFG |=> rd_data == {13'h0, cfg_r};
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("settings readback wrong");
  property p_half;
    txd_oe && rd_en && addr == meter_link_pkg::ADDR_STATUS |=> rd_data[1:0] == 2'b10;
  endproperty
  a_half: assert property (p_half) else $error("state not send while driving");
endmodule : meter_link_assertions
bind meter_serial_link meter_link_assertions #(.ASTER_WAIT_CYC(ASTER_WAIT_CYC),
  .DOLLAR_WAIT_CYC(DOLLAR_WAIT_CYC)) meter_link_assertions_inst (.sys_clk(sys_clk),
  .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .rxd(rxd), .txd(txd), .txd_oe(txd_oe));

// File: verif/host_model.sv
`timescale 1ns/1ns
// ****************************************
// host side of the serial line
// ****************************************
module host_model #(
  parameter int DIV = 8
) (
  // clock
  input wire logic sys_clk,
  // line
  output logic rxd,
  input wire logic txd_oe
);
  int stuck = 0;
  initial rxd = 1'b1;
  task automatic bit_out(input logic b);
    rxd <= b;
    repeat (DIV) @(posedge sys_clk);
  endtask : bit_out
  task automatic send_char(input logic [7:0] c, input logic d8, input logic [1:0] p,
      input logic busy_ok, input logic bad, input int gap);
    int n;
    n = 0;
    while (txd_oe !== busy_ok && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 5000) stuck++;
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) begin
      if (d8 || i < 7) bit_out(c[i]);
    end
    if (p != 2'b00) bit_out(^(c & {d8, 7'h7f}) ^ (p == 2'b01) ^ bad);
    bit_out(1'b1);
  endtask : send_char
endmodule : host_model

// File: verif/tb_top.sv
`timescale 1ns/1ns
// ****************************************
// testbench top
// ****************************************
module tb_top;
  localparam int AW = 300;
  localparam int DW = 40;
  localparam int DIV = 8;
  logic sys_clk;
  logic rst;
  logic [7:0] addr;
  logic [31:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_data;
  logic rxd;
  logic txd;
  logic txd_oe;
  int error_cnt = 0;
  int checked = 0;
  int seed = 6;
  int tgt;
  logic [31:0] rv;
  logic [7:0] c;
  logic [7:0] r;
  logic [7:0] term;
  logic d8;
  logic [1:0] p;
  time t0;
  logic [2:0] fmt [5] = '{3'b100, 3'b101, 3'b110, 3'b000, 3'b010};
  meter_serial_link #(.ASTER_WAIT_CYC(AW), .DOLLAR_WAIT_CYC(DW)) meter_serial_link_inst (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .rxd(rxd), .txd(txd), .txd_oe(txd_oe));
  host_model #(.DIV(DIV)) host_model_inst (.sys_clk(sys_clk), .rxd(rxd), .txd_oe(txd_oe));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(posedge sys_clk);
    rv = rd_data;
  endtask : rd
  task automatic wait_state(input logic [1:0] st);
    int n;
    n = 0;
    rd(meter_link_pkg::ADDR_STATUS);
    while (rv[1:0] !== st && n < 2000) begin
      rd(meter_link_pkg::ADDR_STATUS);
      n++;
    end
    if (n == 2000) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : wait_state
  function automatic logic par_bit(input logic [7:0] v, input logic w8, input logic [1:0] q);
    return ^(v & {w8, 7'h7f}) ^ (q == 2'b01);
  endfunction : par_bit
  task automatic get_frame(input logic [7:0] v, input logic w8, input logic [1:0] q);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 2000) begin
      error_cnt++;
      tally_and_finish();
    end
    n = int'(($time - t0) / 50);
    check(32'(n >= tgt - 2 && n <= tgt + DIV + 4), 32'h1);
    repeat (DIV / 2 - 1) @(posedge sys_clk);
    check(32'({txd_oe, txd}), 32'h2);
    for (int i = 0; i < 8; i++) begin
      if (w8 || i < 7) begin
        repeat (DIV) @(posedge sys_clk);
        check(32'(txd), 32'(v[i]));
      end
    end
    if (q != 2'b00) begin
      repeat (DIV) @(posedge sys_clk);
      check(32'(txd), 32'(par_bit(v, w8, q)));
    end
    repeat (DIV) @(posedge sys_clk);
    check(32'(txd), 32'h1);
    repeat (DIV) @(posedge sys_clk);
    check(32'({txd_oe, txd}), 32'({!w8 && q == 2'b00, 1'b1}));
  endtask : get_frame
  initial begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    addr = 8'h00;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(meter_link_pkg::ADDR_CFG);
    check(rv, 32'h00010823);
    rd(8'h14);
    check(rv, 32'h0);
    for (int i = 0; i < 5; i++) begin
      d8 = fmt[i][2];
      p = fmt[i][1:0];
      term = i[0] ? meter_link_pkg::TERM_DOLLAR : meter_link_pkg::TERM_ASTER;
      tgt = i[0] ? DW : AW;
      c = 8'h41 + 8'($unsigned($random(seed)) % 26);
      wr(meter_link_pkg::ADDR_CFG, {13'h0, p, d8, 16'(DIV)});
      rd(meter_link_pkg::ADDR_CFG);
      check(rv, {13'h0, p, d8, 16'(DIV)});
      host_model_inst.send_char(c, d8, p, 1'b0, i[0], $unsigned($random(seed)) % 20);
      repeat (DIV) @(posedge sys_clk);
      rd(meter_link_pkg::ADDR_RXDATA);
      check(rv, {23'h0, 1'b1, c});
      wr(meter_link_pkg::ADDR_TXDATA, 32'h15a);
      rd(meter_link_pkg::ADDR_STATUS);
      check(32'({rv[3], rv[1:0]}), 32'h0);
      host_model_inst.send_char(term, d8, p, 1'b0, 1'b0, 0);
      t0 = $time;
      wait_state(meter_link_pkg::ST_EXEC);
      check(32'(rv[2]), 32'(i[0]));
      rd(meter_link_pkg::ADDR_RXDATA);
      check(rv, {23'h0, 1'b1, term});
      r = 8'($random(seed)) & {d8, 7'h7f};
      wr(meter_link_pkg::ADDR_TXDATA, {23'h0, 1'b1, r});
      wr(meter_link_pkg::ADDR_TXDATA, {23'h0, 1'b1, ~r});
      fork
        get_frame(r, d8, p);
        host_model_inst.send_char(8'h55, d8, p, 1'b1, 1'b0, 0);
      join
      wait_state(meter_link_pkg::ST_RECV);
      check(32'(rv[4:3]), 32'h0);
    end
    host_model_inst.send_char(meter_link_pkg::TERM_DOLLAR, d8, p, 1'b0, 1'b0, 3);
    wait_state(meter_link_pkg::ST_EXEC);
    wr(meter_link_pkg::ADDR_CTRL, 32'h1);
    rd(meter_link_pkg::ADDR_STATUS);
    check(32'(rv[1:0]), 32'(meter_link_pkg::ST_RECV));
    check(32'(host_model_inst.stuck), 32'h0);
    tally_and_finish();
  end
endmodule : tb_top
